// ===== src/prf_flags.sv
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Events set flags regardless of enables.
// - Flag reads one when pending, zero otherwise.
// - Bits 7,6,5,4,1,0 map gate,adc,rx,tx,t2,t1.
// - Serial receive and transmit flags are read-only.
module prf_flags (
  input wire logic clk,
  input wire logic resetn,
  input wire prf_pkg::prf_events_t events_in,
  input wire prf_pkg::prf_axi_req_t axi_req,
  output var prf_pkg::prf_axi_rsp_t axi_rsp,
  output logic [7:0] peripheral_request_flags_one
);
  import prf_pkg::*;

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] flags;
    logic [5:0] prev;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Registered readies, so that no bus output passes through logic.
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } prf_state_t;

  // State after reset: flags clear, no transfer held, every channel ready.
  localparam prf_state_t STATE_AT_RESET = '{
    flags: PRF_FLAGS_RESET,
    aw_rdy: 1'b1,
    w_rdy: 1'b1,
    ar_rdy: 1'b1,
    default: '0
  };

  prf_state_t state_r;
  prf_state_t state_nxt;
  // Synchronised event levels.
  logic [5:0] ev_sync;
  // Rising edges of the synchronised events.
  logic [5:0] ev_rise;
  // Rising edges mapped to register bit positions.
  logic [7:0] ev_set;
  // Synchronised levels at their register bit positions.
  logic [7:0] ev_level;
  // A write that clears the converter flag in this cycle.
  logic do_clear_adc;

  // Maps a six-bit event vector onto the eight flag positions.
  // flag bit mapping
  function automatic logic [7:0] prf_place(input logic [5:0] ev);
    prf_place = {ev[5], ev[4], ev[3], ev[2], 2'b00, ev[1], ev[0]};
  endfunction

  // Decides whether an address selects a given register word.
  function automatic logic prf_hit(input logic [7:0] addr, input logic [7:0] offs);
    prf_hit = (addr[7:2] == offs[7:2]);
  endfunction

  // Events come from other logic that may be on other clocks, so they are synchronised.
  prf_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(events_in),
    .sync_out(ev_sync)
  );

  // Edge detection on the stable stage only.
  assign ev_rise = ev_sync & ~state_r.prev;
  assign ev_set = prf_place(ev_rise);
  assign ev_level = prf_place(ev_sync);

  // Next-state logic for flags and the bus slave.
  always_comb begin
    logic do_write;
    logic [7:0] clear_mask;
    do_write = 1'b0;
    clear_mask = 8'h00;
    state_nxt = state_r;
    state_nxt.prev = ev_sync;

    // Capture write address and data independently.
    if (axi_req.awvalid && !state_r.aw_held && !state_r.bvalid) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !state_r.w_held && !state_r.bvalid) begin
      state_nxt.w_held = 1'b1;
      state_nxt.w_data = axi_req.wdata;
      state_nxt.w_strb = axi_req.wstrb;
    end

    // Perform the write once both halves are held.
    if (state_r.aw_held && state_r.w_held && !state_r.bvalid) begin
      do_write = 1'b1;
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held = 1'b0;
      state_nxt.bvalid = 1'b1;
      if (prf_hit(state_r.aw_addr, PRF_FLAGS_OFFSET) ||
          prf_hit(state_r.aw_addr, PRF_EVENTS_OFFSET)) begin
        state_nxt.bresp = 2'b00;
      end else begin
        state_nxt.bresp = 2'b10;
      end
    end
    if (state_r.bvalid && axi_req.bready) begin
      state_nxt.bvalid = 1'b0;
    end

    // Writing zero to a writable flag clears it; serial bits ignore writes.
    // serial bits protected
    if (do_write && prf_hit(state_r.aw_addr, PRF_FLAGS_OFFSET) && state_r.w_strb[0]) begin
      clear_mask = ~state_r.w_data[7:0] & PRF_WRITABLE_MASK;
    end

    state_nxt.flags = ((state_r.flags & ~clear_mask) | ev_set) & PRF_WRITABLE_MASK;
    state_nxt.flags = state_nxt.flags | (ev_level & PRF_SERIAL_MASK);

    // Read channel answers one cycle after the address is taken.
    if (axi_req.arvalid && !state_r.rvalid) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = 2'b00;
      if (prf_hit(axi_req.araddr, PRF_FLAGS_OFFSET)) begin
        state_nxt.rdata = {24'h000000, state_r.flags & PRF_IMPL_MASK};
      end else if (prf_hit(axi_req.araddr, PRF_EVENTS_OFFSET)) begin
        state_nxt.rdata = {26'h0000000, ev_sync};
      end else begin
        state_nxt.rdata = 32'h00000000;
        state_nxt.rresp = 2'b10;
      end
    end else if (state_r.rvalid && axi_req.rready) begin
      state_nxt.rvalid = 1'b0;
    end

    // Readies are worked out from the next state so they leave a flip-flop.
    state_nxt.aw_rdy = !state_nxt.aw_held && !state_nxt.bvalid;
    state_nxt.w_rdy = !state_nxt.w_held && !state_nxt.bvalid;
    state_nxt.ar_rdy = !state_nxt.rvalid;
  end

  // Registers the whole state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= STATE_AT_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign axi_rsp.awready = state_r.aw_rdy;
  assign axi_rsp.wready = state_r.w_rdy;
  assign axi_rsp.bvalid = state_r.bvalid;
  assign axi_rsp.bresp = state_r.bresp;
  assign axi_rsp.arready = state_r.ar_rdy;
  assign axi_rsp.rvalid = state_r.rvalid;
  assign axi_rsp.rdata = state_r.rdata;
  assign axi_rsp.rresp = state_r.rresp;
  assign peripheral_request_flags_one = state_r.flags;

  a_event_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    ev_rise[0] |=> state_r.flags[PRF_BIT_T1OVF]) else $error("Overflow event lost.");
  a_gate_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    ev_rise[5] |=> state_r.flags[PRF_BIT_T1GATE]) else $error("Gate event lost.");
  a_match_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    ev_rise[1] |=> state_r.flags[PRF_BIT_T2MATCH]) else $error("Match event lost.");
  a_adc_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    ev_rise[4] |=> state_r.flags[PRF_BIT_ADC]) else $error("Converter event lost.");
  a_unused_zero: assert property (@(posedge clk) disable iff (!resetn)
    state_r.flags[3:2] == 2'b00) else $error("Unimplemented bits set.");
  a_rx_follows: assert property (@(posedge clk) disable iff (!resetn)
    state_r.flags[PRF_BIT_RX] == $past(ev_sync[3])) else $error("Receive flag wrong.");
  a_tx_follows: assert property (@(posedge clk) disable iff (!resetn)
    state_r.flags[PRF_BIT_TX] == $past(ev_sync[2])) else $error("Transmit flag wrong.");
  a_flag_holds: assert property (@(posedge clk) disable iff (!resetn)
    state_r.flags[PRF_BIT_ADC] && !do_clear_adc |=> state_r.flags[PRF_BIT_ADC])
    else $error("Converter flag dropped.");
  a_zero_clears: assert property (@(posedge clk) disable iff (!resetn)
    do_clear_adc && !ev_rise[4] |=> !state_r.flags[PRF_BIT_ADC])
    else $error("Converter flag not cleared.");
  a_read_data: assert property (@(posedge clk) disable iff (!resetn)
    axi_req.arvalid && !state_r.rvalid && axi_req.araddr == PRF_FLAGS_OFFSET
    |=> state_r.rvalid && state_r.rdata[7:0] == $past(state_r.flags))
    else $error("Read data wrong.");
  a_write_resp: assert property (@(posedge clk) disable iff (!resetn)
    state_r.aw_held && state_r.w_held && !state_r.bvalid |=> state_r.bvalid)
    else $error("Write response missing.");
  a_ready_blocked: assert property (@(posedge clk) disable iff (!resetn)
    state_r.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("Write taken while a response is pending.");

  // Helper: a write that clears the converter flag this cycle.
  assign do_clear_adc = state_r.aw_held && state_r.w_held && !state_r.bvalid &&
                        prf_hit(state_r.aw_addr, PRF_FLAGS_OFFSET) && state_r.w_strb[0] &&
                        !state_r.w_data[PRF_BIT_ADC];

endmodule
`default_nettype wire

// ===== src/prf_pkg.sv
package prf_pkg;

  // Byte address of the flag register on the register bus.
  localparam logic [7:0] PRF_FLAGS_OFFSET = 8'h00;
  // Byte address of the raw event level status register.
  localparam logic [7:0] PRF_EVENTS_OFFSET = 8'h04;
  // Value of the flag register after any reset.
  localparam logic [7:0] PRF_FLAGS_RESET = 8'h00;
  // Bit positions of the flags.
  localparam int PRF_BIT_T1OVF = 0;
  localparam int PRF_BIT_T2MATCH = 1;
  localparam int PRF_BIT_TX = 4;
  localparam int PRF_BIT_RX = 5;
  localparam int PRF_BIT_ADC = 6;
  localparam int PRF_BIT_T1GATE = 7;
  // Bits that software may clear by writing zero.
  localparam logic [7:0] PRF_WRITABLE_MASK = 8'hC3;
  // Bits that follow the serial peripheral directly.
  localparam logic [7:0] PRF_SERIAL_MASK = 8'h30;
  // Bits that exist at all.
  localparam logic [7:0] PRF_IMPL_MASK = 8'hF3;
  // Count of cycles the synchroniser delays an event.
  localparam int PRF_SYNC_STAGES = 2;

  // Event inputs from the peripherals, one bit per flag position.
  typedef struct packed {
    logic timer1_gate;
    logic converter;
    logic serial_rx;
    logic serial_tx;
    logic timer2_match;
    logic timer1_ovf;
  } prf_events_t;

  // AXI4-Lite request channels driven by the master.
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } prf_axi_req_t;

  // AXI4-Lite answer channels driven by the slave.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } prf_axi_rsp_t;

endpackage

// ===== src/prf_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for a vector of levels; only the second stage is read outside.
module prf_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // State of the synchroniser.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } prf_sync_state_t;

  prf_sync_state_t state_r;
  prf_sync_state_t state_nxt;

  // Refuses a width that would leave nothing to synchronise.
  if (WIDTH < 1) begin : g_width_check
    $error("Synchroniser width must be at least one.");
  end

  // Shifts the inputs through both stages.
  always_comb begin
    state_nxt.meta = async_in;
    state_nxt.stable = state_r.meta;
  end

  // Registers the stages, clearing them on reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stable;

endmodule
`default_nettype wire

// ===== tb/prf_periph_model.sv
`timescale 1ns/10ps
`default_nettype none

// Stand-in for the peripherals that turns commanded levels into event lines.
module prf_periph_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] lvl_cmd,
  output var prf_pkg::prf_events_t events_out
);
  import prf_pkg::*;
  // Levels change just after an edge, as a synchronous peripheral drives them.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      events_out <= '0;
    end else begin
      events_out <= prf_events_t'(lvl_cmd);
    end
  end
endmodule

`default_nettype wire

// ===== tb/peripheral_irq_request_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none

module peripheral_irq_request_flags_tb;
  import prf_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] lvl = 6'h00;
  prf_events_t ev;
  prf_axi_req_t req = '0;
  prf_axi_rsp_t rsp;
  logic [7:0] flags;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [7:0] exp;
  // Flag position for each event line, least significant first.
  int fb[6] = '{PRF_BIT_T1OVF, PRF_BIT_T2MATCH, PRF_BIT_TX, PRF_BIT_RX, PRF_BIT_ADC, PRF_BIT_T1GATE};

  // The clock has a period of 100 ns.
  initial begin
    forever #50 clk = ~clk;
  end

  prf_periph_model per_u (.clk(clk), .resetn(resetn), .lvl_cmd(lvl), .events_out(ev));
  prf_flags dut_u (.clk(clk), .resetn(resetn), .events_in(ev), .axi_req(req), .axi_rsp(rsp),
    .peripheral_request_flags_one(flags));

  // Prints the verdict and stops the run.
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask

  // Waits a given number of rising clock edges.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One bus write; each channel is held until its own ready is sampled.
  task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int i;
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    r = rsp.bresp;
    req.bready <= 1'b0;
    // One idle edge keeps a following call from raising bready in the same step.
    @(posedge clk);
    if (i == 40) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // One bus read; rready stays high until rvalid is seen.
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    // One idle edge keeps a following call from raising rready in the same step.
    @(posedge clk);
    if (i == 40) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // Reads the flag register and checks both the bus copy and the port.
  task automatic rdf(input logic [7:0] want);
    axr(PRF_FLAGS_OFFSET, rd, rs);
    chk(rd, {24'h000000, want});
    chk({24'h000000, flags}, {24'h000000, want});
  endtask

  // Values after reset, and an unmapped read.
  task automatic t_reset;
    rdf(PRF_FLAGS_RESET);
    axr(8'h08, rd, rs);
    chk({30'h0, rs}, 32'h00000002);
    chk(rd, 32'h00000000);
  endtask

  // Each sticky event sets only its own flag and stays after the level drops.
  task automatic t_sticky;
    exp = 8'h00;
    for (int i = 0; i < 6; i++) begin
      if (i == 2 || i == 3) continue;
      lvl <= 6'h01 << i;
      cyc(6);
      exp[fb[i]] = 1'b1;
      rdf(exp);
      lvl <= 6'h00;
      cyc(6);
      rdf(exp);
    end
  endtask

  // Ones leave flags alone, zeros clear them, bits 3 and 2 stay zero.
  task automatic t_clear;
    axw(PRF_FLAGS_OFFSET, 8'hFF, rs);
    rdf(8'hC3);
    axw(PRF_FLAGS_OFFSET, 8'h7F, rs);
    rdf(8'h43);
    axw(PRF_FLAGS_OFFSET, 8'h00, rs);
    chk({30'h0, rs}, 32'h00000000);
    rdf(8'h00);
    // Writing ones cannot set a flag that is not pending.
    axw(PRF_FLAGS_OFFSET, 8'hFF, rs);
    rdf(8'h00);
  endtask

  // Serial flags follow their levels and ignore writes.
  task automatic t_serial;
    lvl <= 6'h08;
    cyc(6);
    axw(PRF_FLAGS_OFFSET, 8'h00, rs);
    rdf(8'h20);
    lvl <= 6'h04;
    cyc(6);
    rdf(8'h10);
    // The raw level register shows the transmit level alone.
    axr(PRF_EVENTS_OFFSET, rd, rs);
    chk(rd, 32'h00000004);
    lvl <= 6'h00;
    cyc(6);
    rdf(8'h00);
  endtask

  // A reset in mid-run clears a pending flag.
  task automatic t_midreset;
    lvl <= 6'h01;
    cyc(6);
    chk({24'h0, flags}, 32'h00000001);
    resetn <= 1'b0;
    lvl <= 6'h00;
    cyc(2);
    chk({24'h0, flags}, 32'h00000000);
    resetn <= 1'b1;
    cyc(1);
    rdf(8'h00);
  endtask

  // Main sequence after ten cycles of reset.
  initial begin
    cyc(10);
    resetn <= 1'b1;
    cyc(1);
    t_reset();
    t_sticky();
    t_clear();
    t_serial();
    t_midreset();
    tally_and_finish();
  end
endmodule

`default_nettype wire
